// >>> hcl_eeprom_model.sv
// behavioural serial configuration memory on the loader's far side
`timescale 1ns/10ps
module hcl_eeprom_model (
  input  wire logic             ref_clk,
  input  wire logic             spi_sck,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_mosi,
  input  wire logic             two_byte,
  input  wire logic [12:0][7:0] img,
  output logic                  spi_miso
);
  int          cnt = 0;
  int          hb;
  int          b;
  logic [23:0] sh;
  logic        ok;
  logic [8:0]  adr;
  initial spi_miso = 1'b0;
  assign hb = two_byte ? 24 : 16;
  always @(negedge spi_cs_n) cnt = 0;
  always @(posedge spi_sck)
  begin
    if (!spi_cs_n && cnt < hb) sh = {sh[22:0], spi_mosi};
    if (!spi_cs_n) cnt++;
  end
  // a wrong instruction, or in two-byte mode address bits above 8, gives garbage, as the real part would; bytes past 12 read as ones
  always @(negedge spi_sck)
  begin
    if (!spi_cs_n && cnt >= hb)
    begin
      ok  = two_byte ? sh[23:9] == {hcl_pkg::MEM_READ_CMD, 7'h0}
                     : {sh[15:12], 1'b0, sh[10:8]} == hcl_pkg::MEM_READ_CMD;
      adr = two_byte ? sh[8:0] : {sh[11], sh[7:0]};
      b   = int'(adr) + (cnt - hb) / 8;
      spi_miso <= !ok ? ~spi_miso : b > 12 ? 1'b1 : img[b][7 - (cnt - hb) % 8];
    end
  end
  // undriven line: never a steady level
  always @(posedge ref_clk)
    if (spi_cs_n || cnt < hb) spi_miso <= ~spi_miso;
endmodule : hcl_eeprom_model

// >>> hcl_loader.sv
// hub configuration loader top: image fetch, option decode, AHB-Lite registers
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module hcl_loader #(
  parameter logic [15:0] FUSE_VID    = 16'h1234, // arbitrary
  parameter logic [15:0] FUSE_PID    = 16'h5678, // arbitrary
  parameter logic [7:0]  FUSE_DID_HI = 8'h01,    // arbitrary
  parameter int          NPORTS      = 4
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  output logic                    spi_sck,
  output logic                    spi_cs_n,
  output logic                    spi_mosi,
  input  wire logic               spi_miso,
  input  wire logic               mem_present,
  input  wire logic               mem_two_byte,
  input  wire logic [7:0]         req_desc_type,
  output logic                    desc_type_stall,
  output logic                    load_done,
  output logic                    vendor_class,
  output logic [15:0]             id_vendor,
  output logic [15:0]             id_product,
  output logic [7:0]              device_rel_hi,
  output logic [3:0]              live_port_fault_filter,
  output logic [3:0]              idle_port_fault_filter,
  output logic [NPORTS-1:0]       usable_port_mask,
  output logic [2:0]              nbr_ports,
  output logic [NPORTS:0]         device_removable,
  output logic [NPORTS-1:0][2:0]  logical_port_num,
  output logic [7:0]              upstream_current_budget,
  output logic [7:0]              controller_current_draw,
  output logic [7:0]              port_power_settle_time,
  output logic [15:0]             hub_chars,
  output logic                    accept_zero_desc_type,
  output logic                    restrict_to_fs,
  output logic [NPORTS-1:0]       port_lamp_en
);
  typedef enum logic [1:0] {ST_SETTLE, ST_READ, ST_DONE} hcl_state_t;

  typedef struct packed {
    hcl_state_t        st;
    logic [3:0]        settle;
    logic [2:0][1:0]   strap_sync;
    logic              present_q;
    logic              two_byte_q;
    logic              req;
    logic [3:0]        idx;
    logic [3:0]        len;
    logic              all_ff;
    logic [12:0][7:0]  img;
    hcl_pkg::hcl_src_t src;
    logic [1:0]        ctrl;
    logic              dph;
    logic              dwr;
    logic [7:0]        daddr;
    logic [7:0]        filt;
    logic [7:0]        ports;
    logic [7:0]        maxp;
    logic [7:0]        ctrlc;
    logic [7:0]        pwron;
    logic [7:0]        opts;
  } hcl_st_t;

  hcl_st_t s_r;
  hcl_st_t s_nxt;
  hcl_rd_if rd ();

  logic [NPORTS:0][2:0] prefix;
  logic [7:0]  c_filt;
  logic [7:0]  c_ports;
  logic [7:0]  c_maxp;
  logic [7:0]  c_ctrlc;
  logic [7:0]  c_pwron;
  logic [7:0]  c_opts;
  logic        c_hs;
  logic        c_ids;
  logic [15:0] c_chars;
  logic [31:0] c_rd;

  hcl_spi_rd u_rd (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .rd       (rd),
    .spi_sck  (spi_sck),
    .spi_cs_n (spi_cs_n),
    .spi_mosi (spi_mosi),
    .spi_miso (spi_miso)
  );

  assign rd.req      = s_r.req;
  assign rd.two_byte = s_r.two_byte_q;
  assign rd.last     = (s_r.idx + 4'h1) == s_r.len;

  // logical numbering counts usable ports below each physical port
  assign prefix[0] = 3'h0;
  for (genvar i = 0; i < NPORTS; i++)
  begin : g_port
    assign prefix[i+1] = prefix[i] + {2'b00, s_r.ports[4+i]}; // [R8] [R10]
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        logical_port_num[i] <= 3'h0;
        device_removable[i+1] <= 1'b0;
        port_lamp_en[i] <= 1'b0;
      end
      else
      begin
        logical_port_num[i] <= s_r.ports[4+i] ? prefix[i] + 3'h1 : 3'h0; // [R10]
        // hub descriptor sets a bit for a non-removable logical port
        device_removable[i+1] <= (3'(i) < prefix[NPORTS]) && !s_r.ports[i]; // [R9]
        port_lamp_en[i] <= s_r.ports[4+i] && s_r.ctrl[hcl_pkg::CTRL_LAMPS]
                           && !s_r.opts[hcl_pkg::OPT_NO_LAMPS]; // [R17]
      end
    end
  end

  always_comb
  begin
    c_ids = (s_r.src == hcl_pkg::SRC_ID) || (s_r.src == hcl_pkg::SRC_EXT); // [R5] [R6]
    c_filt  = hcl_pkg::DEF_FILTER;
    c_ports = hcl_pkg::DEF_PORTS;
    c_opts  = hcl_pkg::DEF_OPTS;
    c_pwron = hcl_pkg::DEF_PWRON;
    if (s_r.src == hcl_pkg::SRC_EXT)
    begin
      c_filt  = s_r.img[hcl_pkg::B_FILTER]; // [R7]
      c_ports = s_r.img[hcl_pkg::B_PORTS]; // [R8] [R9]
      c_opts  = s_r.img[hcl_pkg::B_OPTS];
      c_pwron = s_r.img[hcl_pkg::B_PWRON]; // [R13]
    end
    c_hs = s_r.ctrl[hcl_pkg::CTRL_HS] && !c_opts[hcl_pkg::OPT_FS_ONLY]; // [R16]
    c_maxp  = c_hs ? hcl_pkg::DEF_MAXP_HS : hcl_pkg::DEF_MAXP_FS; // [R11]
    c_ctrlc = c_hs ? hcl_pkg::DEF_CTRLC_HS : hcl_pkg::DEF_CTRLC_FS; // [R12]
    if (s_r.src == hcl_pkg::SRC_EXT)
    begin
      c_maxp  = s_r.img[hcl_pkg::B_MAXP]; // [R11]
      c_ctrlc = s_r.img[hcl_pkg::B_CTRLC]; // [R12]
    end
    c_chars = 16'h0000;
    c_chars[7] = !s_r.opts[hcl_pkg::OPT_NO_LAMPS]; // [R17]
    c_chars[2] = s_r.opts[hcl_pkg::OPT_COMPOUND]; // [R15]
    c_chars[3] = !s_r.opts[hcl_pkg::OPT_GANGED]; // [R18]
    c_chars[0] = !s_r.opts[hcl_pkg::OPT_GANGED]; // [R18]
  end

  always_comb
  begin
    c_rd = 32'h0000_0000;
    case ({haddr[7:2], 2'b00})
      hcl_pkg::OFS_CTRL:   c_rd = {30'h0, s_nxt.ctrl};
      hcl_pkg::OFS_STATUS: c_rd = {24'h0, vendor_class, 1'b0, prefix[NPORTS],
                                   s_r.src, s_r.st == ST_DONE};
      hcl_pkg::OFS_IDS:    c_rd = {id_product, id_vendor};
      hcl_pkg::OFS_FILT:   c_rd = {16'h0, s_r.filt, device_rel_hi};
      hcl_pkg::OFS_POWER:  c_rd = {s_r.pwron, s_r.ctrlc, s_r.maxp, s_r.ports};
      hcl_pkg::OFS_FLAGS:  c_rd = {8'h0, c_chars, s_r.opts};
      default:             c_rd = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.req = 1'b0;
    s_nxt.strap_sync = {s_r.strap_sync[1:0], {mem_two_byte, mem_present}};
    for (int b = 0; b < 2; b++)
    begin
      if (s_r.strap_sync[1][b] == s_r.strap_sync[2][b])
      begin
        if (b == 0)
          s_nxt.present_q = s_r.strap_sync[2][0];
        else
          s_nxt.two_byte_q = s_r.strap_sync[2][1];
      end
    end
    case (s_r.st)
      ST_SETTLE:
      begin
        s_nxt.settle = s_r.settle + 4'h1;
        if (s_r.settle == 4'(hcl_pkg::SETTLE_CYC - 1))
        begin
          if (s_r.present_q)
          begin
            s_nxt.req = 1'b1; // [R20]
            s_nxt.st = ST_READ;
          end
          else
            s_nxt.st = ST_DONE; // [R1]
        end
      end
      ST_READ:
      begin
        if (rd.bvalid)
        begin
          s_nxt.img[s_r.idx] = rd.data;
          s_nxt.idx = s_r.idx + 4'h1;
          s_nxt.all_ff = s_r.all_ff && (rd.data == hcl_pkg::BLANK_BYTE);
          if (s_r.idx == 4'h0)
          begin
            // layout chosen from byte 0 before later bytes are used
            case (rd.data)
              hcl_pkg::SIG_ID:
              begin
                s_nxt.len = hcl_pkg::ID_LEN; // [R5] [R20]
                s_nxt.src = hcl_pkg::SRC_ID;
              end
              hcl_pkg::SIG_EXT:
              begin
                s_nxt.len = hcl_pkg::EXT_LEN; // [R6] [R20]
                s_nxt.src = hcl_pkg::SRC_EXT;
              end
              hcl_pkg::BLANK_BYTE: s_nxt.len = hcl_pkg::EXT_LEN; // [R3]
              default:             s_nxt.len = hcl_pkg::JUNK_LEN; // [R21]
            endcase
          end
          if (rd.last)
          begin
            s_nxt.st = ST_DONE;
            if (s_r.img[0] == hcl_pkg::BLANK_BYTE && s_r.idx != 4'h0)
              s_nxt.src = s_nxt.all_ff ? hcl_pkg::SRC_BLANK : hcl_pkg::SRC_FUSE; // [R3] [R21]
          end
        end
      end
      ST_DONE:
        s_nxt.st = ST_DONE; // [R4]
      default:
        s_nxt.st = ST_SETTLE;
    endcase
    s_nxt.filt  = c_filt;
    s_nxt.ports = c_ports;
    s_nxt.maxp  = c_maxp;
    s_nxt.ctrlc = c_ctrlc;
    s_nxt.pwron = c_pwron;
    s_nxt.opts  = c_opts;
    if (s_r.dph && s_r.dwr && s_r.daddr == hcl_pkg::OFS_CTRL)
      s_nxt.ctrl = hwdata[1:0];
    s_nxt.dph = 1'b0;
    if (hready)
    begin
      s_nxt.dph = hsel && htrans[1];
      s_nxt.dwr = hwrite;
      s_nxt.daddr = {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_r <= '{st: ST_SETTLE, len: hcl_pkg::EXT_LEN, all_ff: 1'b1, src: hcl_pkg::SRC_FUSE,
               ctrl: hcl_pkg::CTRL_RST, filt: hcl_pkg::DEF_FILTER,
               ports: hcl_pkg::DEF_PORTS, maxp: hcl_pkg::DEF_MAXP_FS,
               ctrlc: hcl_pkg::DEF_CTRLC_FS, pwron: hcl_pkg::DEF_PWRON,
               opts: hcl_pkg::DEF_OPTS, default: '0};
      hrdata <= 32'h0000_0000;
      desc_type_stall <= 1'b0;
      load_done <= 1'b0;
      vendor_class <= 1'b0;
      id_vendor <= FUSE_VID;
      id_product <= FUSE_PID;
      device_rel_hi <= FUSE_DID_HI;
      device_removable[0] <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
      // read data is captured in the address phase for zero wait states
      if (hready && hsel && htrans[1] && !hwrite)
        hrdata <= c_rd;
      desc_type_stall <= !(req_desc_type == hcl_pkg::HUB_DESC_TYPE ||
                           (req_desc_type == hcl_pkg::ZERO_DESC &&
                            s_r.opts[hcl_pkg::OPT_ZERO_DESC])); // [R14]
      load_done <= s_r.st == ST_DONE;
      // class stays frozen after the load; only a new reset re-reads
      vendor_class <= s_r.src == hcl_pkg::SRC_BLANK; // [R3] [R4]
      id_vendor <= c_ids ? {s_r.img[hcl_pkg::B_VID_HI], s_r.img[hcl_pkg::B_VID_LO]}
                         : FUSE_VID; // [R5] [R1]
      id_product <= c_ids ? {s_r.img[hcl_pkg::B_PID_HI], s_r.img[hcl_pkg::B_PID_LO]}
                          : FUSE_PID; // [R5] [R1]
      device_rel_hi <= c_ids ? s_r.img[hcl_pkg::B_DID_HI] : FUSE_DID_HI; // [R5]
      device_removable[0] <= 1'b0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign live_port_fault_filter  = s_r.filt[7:4]; // [R7]
  assign idle_port_fault_filter  = s_r.filt[3:0]; // [R7]
  assign usable_port_mask        = s_r.ports[7:4]; // [R8]
  assign nbr_ports               = prefix[NPORTS]; // [R8]
  assign upstream_current_budget = s_r.maxp; // [R11]
  assign controller_current_draw = s_r.ctrlc; // [R12]
  assign port_power_settle_time  = s_r.pwron; // [R13]
  assign hub_chars               = c_chars;
  assign accept_zero_desc_type   = s_r.opts[hcl_pkg::OPT_ZERO_DESC]; // [R14]
  assign restrict_to_fs          = s_r.opts[hcl_pkg::OPT_FS_ONLY]; // [R16]
endmodule : hcl_loader

// >>> hcl_loader_asserts.sv
// concurrent checks on the loader top ports
`timescale 1ns/10ps
module hcl_loader_asserts #(
  parameter int NPORTS = 4
) (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   spi_sck,
  input wire logic                   spi_cs_n,
  input wire logic [7:0]             req_desc_type,
  input wire logic                   desc_type_stall,
  input wire logic                   load_done,
  input wire logic [NPORTS-1:0]      usable_port_mask,
  input wire logic [2:0]             nbr_ports,
  input wire logic [NPORTS:0]        device_removable,
  input wire logic [NPORTS-1:0][2:0] logical_port_num,
  input wire logic [15:0]            hub_chars,
  input wire logic [NPORTS-1:0]      port_lamp_en
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_hub_type_ok:
    assert property (req_desc_type == 8'h29 |=> !desc_type_stall)
    else $error("hub type stalled");
  chk_odd_type_stall:
    assert property (req_desc_type != 8'h29 && req_desc_type != 8'h00 |=> desc_type_stall)
    else $error("odd type not stalled");
  chk_lamps_off:
    assert property (!hub_chars[7] ##1 !hub_chars[7] |-> port_lamp_en == '0)
    else $error("lamps lit while suppressed");
  chk_port_count:
    assert property ($stable(usable_port_mask) |->
      nbr_ports == 3'($countones(usable_port_mask)))
    else $error("port count wrong");
  chk_last_port_num:
    assert property ($stable(usable_port_mask) && !$past(rst) |-> logical_port_num[NPORTS-1] ==
      (usable_port_mask[NPORTS-1] ? 3'($countones(usable_port_mask)) : 3'h0))
    else $error("last port number wrong");
  chk_removable_hub:
    assert property (device_removable[0] == 1'b0)
    else $error("removable bit0 set");
  chk_read_once:
    assert property (load_done |=> load_done && spi_cs_n)
    else $error("memory touched after load");
  chk_sck_idle:
    assert property (spi_cs_n |-> !spi_sck)
    else $error("clock active while deselected");
endmodule : hcl_loader_asserts

bind hcl_loader hcl_loader_asserts #(.NPORTS(NPORTS)) chk_u (.ref_clk, .rst, .spi_sck,
  .spi_cs_n, .req_desc_type, .desc_type_stall, .load_done, .usable_port_mask, .nbr_ports,
  .device_removable, .logical_port_num, .hub_chars, .port_lamp_en);

// >>> hcl_loader_tb.sv
// self-checking bench for the hub configuration loader
`timescale 1ns/10ps
module hcl_loader_tb;
  logic             ref_clk, rst, hsel, hwrite, hreadyout, spi_sck, spi_cs_n, spi_mosi;
  logic             spi_miso, mem_present, mem_two_byte, desc_type_stall, load_done;
  logic             vendor_class, accept_zero_desc_type, restrict_to_fs, pk_v, dp_rd;
  logic [31:0]      haddr, hwdata, hrdata, v, w;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [7:0]       req_desc_type, pb, op, d;
  logic [3:0]       live_port_fault_filter, idle_port_fault_filter, port_lamp_en;
  logic [4:0]       device_removable, drm;
  logic [3:0][2:0]  logical_port_num;
  logic [15:0]      hub_chars;
  logic [12:0][7:0] img;
  logic [39:0]      rx, rq[$];
  logic [40:0]      pq[$];
  int               fails, tests_run;
  wire  [40:0]      pw = {live_port_fault_filter, idle_port_fault_filter, hub_chars[7:0],
    vendor_class, restrict_to_fs, accept_zero_desc_type, desc_type_stall,
    port_lamp_en, device_removable & drm, logical_port_num};

  // fuse identity values are arbitrary
  hcl_loader #(.FUSE_VID(16'hA11A), .FUSE_PID(16'hB22B), .FUSE_DID_HI(8'h3C)) dut_u (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp(), .hrdata, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .mem_present,
    .mem_two_byte, .req_desc_type, .desc_type_stall, .load_done, .vendor_class,
    .id_vendor(), .id_product(), .device_rel_hi(), .live_port_fault_filter,
    .idle_port_fault_filter, .usable_port_mask(), .nbr_ports(), .device_removable,
    .logical_port_num, .upstream_current_budget(), .controller_current_draw(),
    .port_power_settle_time(), .hub_chars, .accept_zero_desc_type, .restrict_to_fs,
    .port_lamp_en);
  hcl_eeprom_model mem_u (.ref_clk, .spi_sck, .spi_cs_n, .spi_mosi,
    .two_byte(mem_two_byte), .img, .spi_miso);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic cmp(input string s, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : cmp

  always @(posedge ref_clk)
  begin
    if (dp_rd && hreadyout === 1'b1)
    begin
      rx = rq.pop_front();
      cmp($sformatf("reg_%h", rx[39:32]), 48'(rx[31:0]), 48'(hrdata));
    end
    if (hreadyout === 1'b1)
      dp_rd = hsel && htrans[1] && !hwrite;
    if (pk_v)
      cmp("ports", 48'(pq.pop_front()), 48'(pw));
  end

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    int n;
    if (!wr) rq.push_back({a, dt});
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dt;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 80);
    if (n >= 80) begin fails++; stop_test(); end
  endtask : ahb

  task automatic boot(input logic p, input logic two, input logic [12:0][7:0] im);
    int n;
    img = im;
    mem_present <= p;
    mem_two_byte <= two;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (load_done !== 1'b1 && n < 9000);
    if (n >= 9000) begin fails++; stop_test(); end
  endtask : boot

  task automatic regs(input logic [31:0] ids, input logic [15:0] fd, input logic [31:0] p,
                      input logic [7:0] st);
    ahb(1'b0, hcl_pkg::OFS_STATUS, {24'h0, st});
    ahb(1'b0, hcl_pkg::OFS_IDS, ids);
    ahb(1'b0, hcl_pkg::OFS_FILT, {16'h0, fd});
    ahb(1'b0, hcl_pkg::OFS_POWER, p);
  endtask : regs

  function automatic logic [11:0] lmap(input logic [3:0] u);
    logic [2:0] c;
    lmap = '0;
    c = 3'h0;
    for (int i = 0; i < 4; i++) if (u[i]) begin c++; lmap[i*3+:3] = c; end
  endfunction : lmap

  task automatic chk_ports(input logic [7:0] f, input logic [7:0] b8, input logic [7:0] o,
                           input logic lm);
    logic [7:0] t;
    logic       st;
    drm = 5'(((1 << $countones(b8[7:4])) - 1) << 1);
    for (int k = 0; k < 3; k++)
    begin
      t = k == 0 ? 8'h00 : k == 1 ? hcl_pkg::HUB_DESC_TYPE : 8'h06;
      st = !(t == 8'h29 || (t == 8'h00 && o[7]));
      req_desc_type <= t;
      pq.push_back({f, !o[4], 3'h0, !o[2], o[6], 1'b0, !o[2],
                    1'b0, o[5], o[7], st, b8[7:4] & {4{lm & !o[4]}},
                    {~b8[3:0], 1'b0} & drm, lmap(b8[7:4])});
      repeat (2) @(posedge ref_clk);
      pk_v <= 1'b1;
      @(posedge ref_clk);
      pk_v <= 1'b0;
      @(posedge ref_clk);
    end
  endtask : chk_ports

  initial
  begin
    v = $urandom(95651);
    {rst, hsel, hwrite, mem_present, mem_two_byte, pk_v} = 6'h20;
    {haddr, hwdata, htrans, req_desc_type} = '0;
    hsize = 3'h2;
    img = '1;
    fails = 0;
    tests_run = 0;
    @(posedge ref_clk);
    boot(1'b0, 1'b0, '1);
    regs({16'hB22B, 16'hA11A}, 16'h883C, 32'h325028FF, 8'h21);
    chk_ports(8'h88, 8'hFF, hcl_pkg::DEF_OPTS, 1'b1);
    d = 8'($urandom);
    boot(1'b1, 1'b1, {48'hFFFF_FFFF_FFFF, d, 8'h00, v, hcl_pkg::SIG_ID});
    img = '1;
    regs(v, {8'h88, d}, 32'h325028FF, 8'h23);
    ahb(1'b1, hcl_pkg::OFS_CTRL, 32'h3);
    ahb(1'b0, hcl_pkg::OFS_CTRL, 32'h3);
    ahb(1'b0, hcl_pkg::OFS_POWER, 32'h32AE57FF);
    ahb(1'b1, 8'h3C, v);
    ahb(1'b0, 8'h3C, 32'h0);
    ahb(1'b1, hcl_pkg::OFS_CTRL, 32'h1);
    chk_ports(8'h88, 8'hFF, hcl_pkg::DEF_OPTS, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      v = $urandom;
      w = $urandom;
      d = 8'($urandom);
      pb = 8'($urandom);
      if (pb[7:4] == 4'h0) pb[7:4] = 4'h9;
      op = 8'($urandom) & 8'hF4;
      boot(1'b1, k[0], {op, w[31:8], pb, w[7:0], d, 8'h00, v, hcl_pkg::SIG_EXT});
      regs(v, {w[7:0], d}, {w[31:8], pb}, {2'h0, 3'($countones(pb[7:4])), 3'h5});
      chk_ports(w[7:0], pb, op, 1'b1);
    end
    boot(1'b1, 1'b0, '1);
    ahb(1'b0, hcl_pkg::OFS_STATUS, 32'hA7);
    boot(1'b1, 1'b0, {{7{8'hFF}}, 8'h00, {5{8'hFF}}});
    ahb(1'b0, hcl_pkg::OFS_STATUS, 32'h21);
    boot(1'b1, 1'b1, {{12{8'hFF}}, 8'h5A});
    regs({16'hB22B, 16'hA11A}, 16'h883C, 32'h325028FF, 8'h21);
    stop_test();
  end
endmodule : hcl_loader_tb

// >>> hcl_pkg.sv
// constants, types and field layout of the hub configuration loader
// Contract
// R1: with no configuration memory present, use factory fuse settings.
// R2: read memories with two-byte address or ninth bit inside instruction.
// R3: an all-0xFF memory makes the hub enumerate as vendor class.
// R4: a newly programmed image takes effect only after a power cycle.
// R5: identity image: 0xD0, VID lo/hi, PID lo/hi, reserved, DID high.
// R6: extended image: 0xD2, same identity bytes, then option bytes 7-12.
// R7: byte 7 holds live/idle port fault filter times, default 0x88.
// R8: byte 8 bits 7-4 usable ports, giving port count; default 0xFF.
// R9: byte 8 bits 3-0 removable logical ports, reported as DeviceRemovable.
// R10: logical ports number from 1 over usable physical ports only.
// R11: byte 9 is bMaxPower in 2 mA; defaults 0x28 FS, 0x57 HS.
// R12: byte 10 is bHubContrCurrent in mA; defaults 0x50 FS, 0xAE HS.
// R13: byte 11 is bPwrOn2PwrGood in 2 ms units; default 0x32.
// R14: byte 12 bit 7 lets type 0x00 pass; else only 0x29, others stall.
// R15: byte 12 bit 6 compound flag goes to hub characteristics b2.
// R16: byte 12 bit 5 restricts operation to full speed.
// R17: byte 12 bit 4 turns lamps off and clears characteristics b7.
// R18: byte 12 bit 2 ganged power, reflected in b4, b3, b1, b0; the loader drives only b3 and b0 from it.
// R19: writer programs byte 12 bits 3, 1, 0 as zero.
// R20: read memory once after reset from byte 0; signature picks layout.
// R21: unknown signature, not blank, falls back to fuse configuration.
package hcl_pkg;
  localparam int          CLK_MHZ       = 100;
  localparam int          SPI_HALF_NS   = 80;
  localparam int          SPI_HALF_CYC  = (SPI_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          SETTLE_CYC    = 8;
  localparam logic [7:0]  SIG_ID        = 8'hD0;
  localparam logic [7:0]  SIG_EXT       = 8'hD2;
  localparam logic [7:0]  BLANK_BYTE    = 8'hFF;
  localparam logic [7:0]  MEM_READ_CMD  = 8'h03;
  localparam logic [7:0]  HUB_DESC_TYPE = 8'h29;
  localparam logic [7:0]  ZERO_DESC     = 8'h00;
  localparam logic [3:0]  ID_LEN        = 4'h7;
  localparam logic [3:0]  EXT_LEN       = 4'hD;
  localparam logic [3:0]  JUNK_LEN      = 4'h2;
  localparam int          B_SIG         = 0;
  localparam int          B_VID_LO      = 1;
  localparam int          B_VID_HI      = 2;
  localparam int          B_PID_LO      = 3;
  localparam int          B_PID_HI      = 4;
  localparam int          B_DID_HI      = 6;
  localparam int          B_FILTER      = 7;
  localparam int          B_PORTS       = 8;
  localparam int          B_MAXP        = 9;
  localparam int          B_CTRLC       = 10;
  localparam int          B_PWRON       = 11;
  localparam int          B_OPTS        = 12;
  localparam logic [7:0]  DEF_FILTER    = 8'h88;
  localparam logic [7:0]  DEF_PORTS     = 8'hFF;
  localparam logic [7:0]  DEF_MAXP_FS   = 8'h28;
  localparam logic [7:0]  DEF_MAXP_HS   = 8'h57;
  localparam logic [7:0]  DEF_CTRLC_FS  = 8'h50;
  localparam logic [7:0]  DEF_CTRLC_HS  = 8'hAE;
  localparam logic [7:0]  DEF_PWRON     = 8'h32;
  localparam logic [7:0]  DEF_OPTS      = 8'h80;
  localparam int          OPT_ZERO_DESC = 7;
  localparam int          OPT_COMPOUND  = 6;
  localparam int          OPT_FS_ONLY   = 5;
  localparam int          OPT_NO_LAMPS  = 4;
  localparam int          OPT_GANGED    = 2;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_IDS       = 8'h08;
  localparam logic [7:0]  OFS_FILT      = 8'h0C;
  localparam logic [7:0]  OFS_POWER     = 8'h10;
  localparam logic [7:0]  OFS_FLAGS     = 8'h14;
  localparam logic [1:0]  CTRL_RST      = 2'h2;
  localparam int          CTRL_HS       = 0;
  localparam int          CTRL_LAMPS    = 1;
  typedef enum logic [1:0] {SRC_FUSE, SRC_ID, SRC_EXT, SRC_BLANK} hcl_src_t;
endpackage : hcl_pkg

// >>> hcl_rd_if.sv
// byte stream link between the loader and the serial memory reader
`timescale 1ns/10ps
interface hcl_rd_if;
  logic       req;
  logic       two_byte;
  logic       last;
  logic       bvalid;
  logic [7:0] data;
  logic       busy;
  modport loader (output req, output two_byte, output last,
                  input bvalid, input data, input busy);
  modport reader (input req, input two_byte, input last,
                  output bvalid, output data, output busy);
endinterface : hcl_rd_if

// >>> hcl_spi_rd.sv
// serial memory reader: read command from address 0, then streams bytes
`timescale 1ns/10ps
module hcl_spi_rd (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  hcl_rd_if.reader   rd,
  output logic       spi_sck,
  output logic       spi_cs_n,
  output logic       spi_mosi,
  input  wire logic  spi_miso
);
  typedef struct packed {
    logic       active;
    logic       in_hdr;
    logic [1:0] hdr_left;
    logic [7:0] div;
    logic       sck;
    logic       cs_n;
    logic [7:0] sh_out;
    logic [7:0] sh_in;
    logic [2:0] bitn;
    logic       bvalid;
    logic [7:0] data;
    logic [2:0] miso_sync;
    logic       miso_q;
  } hcl_rd_st_t;

  hcl_rd_st_t s_r;
  hcl_rd_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.bvalid = 1'b0;
    s_nxt.miso_sync = {s_r.miso_sync[1:0], spi_miso};
    if (s_r.miso_sync[1] == s_r.miso_sync[2])
      s_nxt.miso_q = s_r.miso_sync[2];
    if (!s_r.active)
    begin
      s_nxt.sck = 1'b0;
      s_nxt.cs_n = 1'b1;
      if (rd.req)
      begin
        s_nxt.active = 1'b1;
        s_nxt.cs_n = 1'b0;
        s_nxt.in_hdr = 1'b1;
        s_nxt.div = 8'h00;
        s_nxt.bitn = 3'h0;
        // address 0: ninth bit is zero; two-byte parts take a plain command
        s_nxt.sh_out = hcl_pkg::MEM_READ_CMD; // [R2]
        s_nxt.hdr_left = rd.two_byte ? 2'h2 : 2'h1; // [R2]
      end
    end
    else if (s_r.div == 8'(hcl_pkg::SPI_HALF_CYC - 1))
    begin
      s_nxt.div = 8'h00;
      if (!s_r.sck)
        s_nxt.sck = 1'b1;
      else
      begin
        // sample on the falling tick: the synchroniser delay is covered
        s_nxt.sck = 1'b0;
        s_nxt.sh_in = {s_r.sh_in[6:0], s_r.miso_q};
        s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
        s_nxt.bitn = s_r.bitn + 3'h1;
        if (s_r.bitn == 3'h7)
        begin
          s_nxt.sh_out = 8'h00;
          if (s_r.in_hdr)
          begin
            if (s_r.hdr_left == 2'h0)
              s_nxt.in_hdr = 1'b0;
            else
              s_nxt.hdr_left = s_r.hdr_left - 2'h1;
          end
          else
          begin
            s_nxt.bvalid = 1'b1;
            s_nxt.data = {s_r.sh_in[6:0], s_r.miso_q};
            if (rd.last)
            begin
              s_nxt.active = 1'b0;
              s_nxt.cs_n = 1'b1;
            end
          end
        end
      end
    end
    else
      s_nxt.div = s_r.div + 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s_r <= '{cs_n: 1'b1, default: '0};
    else
      s_r <= s_nxt;
  end

  assign spi_sck   = s_r.sck;
  assign spi_cs_n  = s_r.cs_n;
  assign spi_mosi  = s_r.sh_out[7];
  assign rd.bvalid = s_r.bvalid;
  assign rd.data   = s_r.data;
  assign rd.busy   = s_r.active;
endmodule : hcl_spi_rd
